// ### rtl/mpps_sequencer.sv
// Host-side supply and mirror park sequencer
//
// Behaviour
// - All supply enables come from this sequencer, never from free supply ramps.
// - Logic and interface supplies settle before offset, bias or reset supply enable.
// - Offset enabled one cycle before bias; bias removed before offset.
// - Mirror reset supply enabled with bias, after the core supplies settle.
// - Logic inputs to the controller held low until both core supplies are good.
// - Planned off, command variant: send standby, wait at least 20 ms.
// - Power loss, command variant: send standby, hold all supplies 20 ms.
// - Standby and normal commands leave through a valid/ready command port.
// - Resume from park on command variant sends the normal mode command.
// - Planned off, pin variant: float request held at least 500 us.
// - Power loss, pin variant: float request, supplies held 500 us.
// - Pin variant restart: controller reset held low 50 ms, then high.
// - Controller power-down signal parks, then drops bias, offset, reset supplies.
// - Core supplies stay enabled until the high rails have discharged.
`timescale 1ns/10ps

module mpps_sequencer #(
  parameter int unsigned STBY_CYC  = mpps_pkg::STBY_CYC,
  parameter int unsigned FLOAT_CYC = mpps_pkg::FLOAT_CYC,
  parameter int unsigned RSTL_CYC  = mpps_pkg::RSTL_CYC
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   srst_i,
  input  wire logic                   power_on_i,
  input  wire logic                   power_off_i,
  input  wire logic                   resume_i,
  input  wire logic                   logic_good_i,
  input  wire logic                   intf_good_i,
  input  wire logic                   rails_low_i,
  input  wire logic                   power_loss_i,
  input  wire logic                   power_down_n_i,
  input  wire logic                   pin_variant_i,
  input  wire logic                   cmd_ready_i,
  output logic                        cmd_valid_o,
  output logic                        cmd_mode_o,
  output mpps_pkg::mpps_supply_s      supply_en_o,
  output logic                        logic_inputs_en_o,
  output logic                        float_request_o,
  output logic                        controller_reset_n_o,
  output logic                        running_o,
  output logic                        parked_o
);
  import mpps_pkg::*;

  localparam logic [CNT_W-1:0] STBY_LAST  = CNT_W'(STBY_CYC - 1);
  localparam logic [CNT_W-1:0] FLOAT_LAST = CNT_W'(FLOAT_CYC - 1);
  localparam logic [CNT_W-1:0] RSTL_LAST  = CNT_W'(RSTL_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_MAX    = '1;

  // Pins from the supplies and the controller are asynchronous
  logic [SY_W-1:0] sync1_r;
  logic [SY_W-1:0] sync2_r;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {pin_variant_i, power_down_n_i, power_loss_i,
                  rails_low_i, intf_good_i, logic_good_i};
      sync2_r <= sync1_r;
    end
  end

  logic core_good;
  logic pin_var;
  logic fail_req;
  assign core_good = sync2_r[SY_LOGIC_GOOD] & sync2_r[SY_INTF_GOOD];
  assign pin_var   = sync2_r[SY_PIN_VAR];
  // A low power-down signal is only trusted once the core is up
  assign fail_req  = sync2_r[SY_LOSS] | (core_good & ~sync2_r[SY_PDN_N]);

  mpps_state_e      state_r;
  mpps_state_e      state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             acked_r;
  logic             acked_nxt;
  logic             off_pend_r;
  logic             off_pend_nxt;
  mpps_supply_s     sup_r;
  mpps_supply_s     sup_nxt;
  logic             gate_r;
  logic             gate_nxt;
  logic             float_r;
  logic             float_nxt;
  logic             rstn_r;
  logic             rstn_nxt;
  logic             cmd_v_r;
  logic             cmd_v_nxt;
  logic             cmd_m_r;
  logic             cmd_m_nxt;
  logic             hold_done;

  assign hold_done = acked_r & (cnt_r == (pin_var ? FLOAT_LAST : STBY_LAST));

  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 1'b1;
    acked_nxt    = acked_r;
    off_pend_nxt = off_pend_r | power_off_i | fail_req;
    sup_nxt      = sup_r;
    gate_nxt     = gate_r & core_good;
    float_nxt    = float_r;
    rstn_nxt     = rstn_r & core_good;
    cmd_v_nxt    = cmd_v_r & ~cmd_ready_i;
    cmd_m_nxt    = cmd_m_r;
    unique case (state_r)
      S_OFF: begin
        sup_nxt      = SUPPLY_OFF;
        off_pend_nxt = 1'b0;
        float_nxt    = 1'b0;
        rstn_nxt     = 1'b0;
        gate_nxt     = 1'b0;
        if (power_on_i && !power_off_i && !sync2_r[SY_LOSS]) begin
          state_nxt        = S_CORE;
          sup_nxt.logic_en = 1'b1;
          sup_nxt.intf_en  = 1'b1;
        end
      end
      S_CORE: begin
        if (core_good) begin
          state_nxt         = S_OFFS;
          sup_nxt.offset_en = 1'b1;
          gate_nxt          = 1'b1;
          rstn_nxt          = 1'b1;
        end else if (off_pend_r) begin
          state_nxt = S_DISCH;
        end
      end
      S_OFFS: begin
        state_nxt         = S_RAILS;
        sup_nxt.bias_en   = 1'b1;
        sup_nxt.mreset_en = 1'b1;
      end
      S_RAILS: begin
        state_nxt = S_RUN;
      end
      S_RUN: begin
        if (off_pend_r) begin
          state_nxt = S_PARK;
          cnt_nxt   = '0;
          acked_nxt = pin_var;
          if (pin_var) begin
            float_nxt = 1'b1;
          end else begin
            cmd_v_nxt = 1'b1;
            cmd_m_nxt = CMD_STANDBY;
          end
        end
      end
      S_PARK: begin
        // Resume cancels a planned off so the park ends held; a live failure still wins
        if (resume_i) begin
          off_pend_nxt = power_off_i | fail_req;
        end
        // The standby hold starts only once the command was taken
        if (!acked_r) begin
          cnt_nxt = '0;
          if (cmd_v_r && cmd_ready_i) begin
            acked_nxt = 1'b1;
          end
        end else if (hold_done) begin
          state_nxt = off_pend_r ? S_DROPB : S_HELD;
        end
      end
      S_HELD: begin
        if (off_pend_r) begin
          state_nxt = S_DROPB;
        end else if (resume_i) begin
          cnt_nxt = '0;
          if (pin_var) begin
            state_nxt = S_RSTL;
            float_nxt = 1'b0;
            rstn_nxt  = 1'b0;
          end else begin
            state_nxt = S_WAKE;
            cmd_v_nxt = 1'b1;
            cmd_m_nxt = CMD_NORMAL;
          end
        end
      end
      S_RSTL: begin
        if (cnt_r == RSTL_LAST) begin
          state_nxt = S_RUN;
          rstn_nxt  = core_good;
          off_pend_nxt = power_off_i | fail_req;
        end
      end
      S_WAKE: begin
        if (cmd_v_r && cmd_ready_i) begin
          state_nxt    = S_RUN;
          off_pend_nxt = power_off_i | fail_req;
        end
      end
      S_DROPB: begin
        // Bias goes first so the bias-offset delta never reverses
        state_nxt       = S_DISCH;
        sup_nxt.bias_en = 1'b0;
      end
      S_DISCH: begin
        sup_nxt.offset_en = 1'b0;
        sup_nxt.mreset_en = 1'b0;
        gate_nxt          = 1'b0;
        rstn_nxt          = 1'b0;
        float_nxt         = 1'b0;
        if (!sup_r.offset_en && sync2_r[SY_RAILS_LOW]) begin
          state_nxt        = S_OFF;
          sup_nxt.logic_en = 1'b0;
          sup_nxt.intf_en  = 1'b0;
        end
      end
    endcase
    if (state_nxt != state_r && state_r != S_HELD && state_r != S_RUN) begin
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_r    <= S_OFF;
      cnt_r      <= '0;
      acked_r    <= 1'b0;
      off_pend_r <= 1'b0;
      sup_r      <= SUPPLY_OFF;
      gate_r     <= 1'b0;
      float_r    <= 1'b0;
      rstn_r     <= 1'b0;
      cmd_v_r    <= 1'b0;
      cmd_m_r    <= CMD_STANDBY;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      acked_r    <= acked_nxt;
      off_pend_r <= off_pend_nxt;
      sup_r      <= sup_nxt;
      gate_r     <= gate_nxt;
      float_r    <= float_nxt;
      rstn_r     <= rstn_nxt;
      cmd_v_r    <= cmd_v_nxt;
      cmd_m_r    <= cmd_m_nxt;
    end
  end

  assign supply_en_o          = sup_r;
  assign logic_inputs_en_o    = gate_r;
  assign float_request_o      = float_r;
  assign controller_reset_n_o = rstn_r;
  assign cmd_valid_o          = cmd_v_r;
  assign cmd_mode_o           = cmd_m_r;
  assign running_o            = (state_r == S_RUN);
  assign parked_o             = (state_r == S_HELD);

  // Lengths of holds seen at the pins, read only by the checks below
  logic [CNT_W-1:0] flt_len_r;
  logic [CNT_W-1:0] flt_len_nxt;
  logic [CNT_W-1:0] rst_len_r;
  logic [CNT_W-1:0] rst_len_nxt;
  logic [CNT_W-1:0] stb_len_r;
  logic [CNT_W-1:0] stb_len_nxt;

  always_comb begin
    flt_len_nxt = !float_r ? '0 : (flt_len_r == CNT_MAX) ? flt_len_r : flt_len_r + 1'b1;
    rst_len_nxt = rstn_r ? '0 : (rst_len_r == CNT_MAX) ? rst_len_r : rst_len_r + 1'b1;
    stb_len_nxt = (stb_len_r == CNT_MAX) ? stb_len_r : stb_len_r + 1'b1;
    if (cmd_v_r && cmd_ready_i && cmd_m_r == CMD_STANDBY) begin
      stb_len_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      flt_len_r <= '0;
      rst_len_r <= '0;
      stb_len_r <= '0;
    end else begin
      flt_len_r <= flt_len_nxt;
      rst_len_r <= rst_len_nxt;
      stb_len_r <= stb_len_nxt;
    end
  end

  a_core_first: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (sup_r.offset_en | sup_r.bias_en | sup_r.mreset_en) |-> (sup_r.logic_en & sup_r.intf_en))
    else $error("rail enabled without core supplies");

  a_gate_low: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (gate_r | rstn_r) |-> $past(core_good))
    else $error("logic input driven high before core good");

  a_bias_order: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ($rose(sup_r.bias_en) |-> $past(sup_r.offset_en)) and ($fell(sup_r.offset_en) |-> !sup_r.bias_en))
    else $error("bias and offset order broken");

  a_float_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    $fell(float_r) |-> ($past(flt_len_r) >= FLOAT_LAST))
    else $error("float request shorter than hold");

  a_rails_after: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ($fell(sup_r.bias_en) && !pin_var) |-> (stb_len_r >= STBY_LAST))
    else $error("rails dropped before standby hold");

  a_rst_pulse: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ($rose(rstn_r) && $past(state_r == S_RSTL)) |-> ($past(rst_len_r) >= RSTL_LAST))
    else $error("controller reset pulse too short");

  a_core_stays: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ($fell(sup_r.logic_en) || $fell(sup_r.intf_en)) |-> ($past(sync2_r[SY_RAILS_LOW]) && !sup_r.offset_en))
    else $error("core supply removed before rails discharged");

  a_cmd_stable: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (cmd_v_r && !cmd_ready_i) |=> (cmd_v_r && $stable(cmd_m_r)))
    else $error("command dropped before taken");

  a_fail_park: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (state_r == S_RUN && fail_req) |-> ##[1:2] (state_r == S_PARK && (float_r || cmd_v_r || acked_r)))
    else $error("power failure not parked");

  a_wake_cmd: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ($past(state_r == S_WAKE) && state_r == S_RUN) |-> $past(cmd_v_r && cmd_ready_i && (cmd_m_r == CMD_NORMAL)))
    else $error("resume without normal command");

endmodule

// ### common/mpps_pkg.sv
// Shared constants and types for the mirror park power sequencer
package mpps_pkg;

  localparam longint unsigned CLK_HZ     = 64'd25_000_000;
  localparam longint unsigned T_STBY_MS  = 64'd20;
  localparam longint unsigned T_FLOAT_US = 64'd500;
  localparam longint unsigned T_RSTL_MS  = 64'd50;

  // Least times round up to whole cycles
  localparam int unsigned STBY_CYC  = int'((T_STBY_MS * CLK_HZ + 64'd999) / 64'd1000);
  localparam int unsigned FLOAT_CYC = int'((T_FLOAT_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);
  localparam int unsigned RSTL_CYC  = int'((T_RSTL_MS * CLK_HZ + 64'd999) / 64'd1000);

  localparam int unsigned CNT_W = 21;

  // Synchronised pin indices
  localparam int unsigned SY_LOGIC_GOOD = 0;
  localparam int unsigned SY_INTF_GOOD  = 1;
  localparam int unsigned SY_RAILS_LOW  = 2;
  localparam int unsigned SY_LOSS       = 3;
  localparam int unsigned SY_PDN_N      = 4;
  localparam int unsigned SY_PIN_VAR    = 5;
  localparam int unsigned SY_W          = 6;

  localparam logic CMD_STANDBY = 1'b0;
  localparam logic CMD_NORMAL  = 1'b1;

  typedef struct packed {
    logic logic_en;
    logic intf_en;
    logic offset_en;
    logic bias_en;
    logic mreset_en;
  } mpps_supply_s;

  localparam mpps_supply_s SUPPLY_OFF = '0;

  typedef enum logic [10:0] {
    S_OFF   = 11'h001,
    S_CORE  = 11'h002,
    S_OFFS  = 11'h004,
    S_RAILS = 11'h008,
    S_RUN   = 11'h010,
    S_PARK  = 11'h020,
    S_HELD  = 11'h040,
    S_RSTL  = 11'h080,
    S_WAKE  = 11'h100,
    S_DROPB = 11'h200,
    S_DISCH = 11'h400
  } mpps_state_e;

endpackage

// ### sim/mpps_partner.sv
// Device-side model: supply settling, rail discharge, command engine and mirror park
`timescale 1ns/10ps
module mpps_partner
  import mpps_pkg::*;
#(
  parameter int STBY  = 20,
  parameter int FLOAT = 10
) (
  input  wire logic         sys_clk_i,
  input  wire mpps_supply_s sup_i,
  input  wire logic         valid_i,
  input  wire logic         mode_i,
  input  wire logic         float_i,
  input  wire logic [2:0]   dly_i,
  output logic              lgood_o,
  output logic              igood_o,
  output logic              rlow_o,
  output logic              ready_o,
  output logic              flat_o
);
  int   set_q  = 0;
  int   dis_q  = 9;
  int   wait_q = 0;
  int   park_q = 0;
  logic stby_q = 1'b0;
  initial begin
    lgood_o = 1'b0;
    igood_o = 1'b0;
    rlow_o  = 1'b1;
    ready_o = 1'b0;
  end
  // Mirrors only count as flat once the park request has stood its full time
  assign flat_o = (stby_q && park_q >= STBY) || (float_i && park_q >= FLOAT);
  always @(posedge sys_clk_i) begin
    // Interface supply settles a cycle after logic, so the two goods differ
    set_q   <= (sup_i.logic_en && sup_i.intf_en) ? set_q + 1 : 0;
    lgood_o <= sup_i.logic_en && set_q >= dly_i;
    igood_o <= sup_i.intf_en && set_q > dly_i;
    dis_q   <= (sup_i.offset_en || sup_i.bias_en || sup_i.mreset_en) ? 0 : dis_q + 1;
    rlow_o  <= dis_q > 3;
    wait_q  <= (valid_i && !ready_o) ? wait_q + 1 : 0;
    ready_o <= valid_i && !ready_o && wait_q >= dly_i;
    if (valid_i && ready_o)
      stby_q <= (mode_i == CMD_STANDBY);
    if (!sup_i.logic_en)
      stby_q <= 1'b0;
    park_q <= (stby_q || float_i) ? park_q + 1 : 0;
  end
endmodule

// ### sim/testbench.sv
// Self-checking bench for the mirror park power sequencer
`timescale 1ns/10ps
module testbench;
  import mpps_pkg::*;
  localparam int STBY = 20;
  localparam int FLT  = 10;
  localparam int RSTL = 30;
  logic         sys_clk_i = 1'b0;
  logic         srst_i    = 1'b1;
  logic         pwr_on    = 1'b0;
  logic         pwr_off   = 1'b0;
  logic         loss      = 1'b0;
  logic         pdn_n     = 1'b1;
  logic         pin       = 1'b0;
  logic         resume    = 1'b0;
  logic [2:0]   dly       = 3'h0;
  logic         lgood, igood, rlow, ready, flat, valid, mode, gate, flt_o, rst_n, run_o, park_o;
  logic         prev_v, prev_r, prev_m, prev_rn, saw_flt, saw_stby, saw_park, saw_norm;
  int           rst_lo       = 0;
  mpps_supply_s sup, prev_s;
  mpps_supply_s exp_q[$];
  int           mismatches   = 0;
  int           total_checks = 0;
  int           cycles       = 0;
  int           seed         = 50643;

  always #20 sys_clk_i = ~sys_clk_i;

  mpps_sequencer #(.STBY_CYC(STBY), .FLOAT_CYC(FLT), .RSTL_CYC(RSTL)) dut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .power_on_i(pwr_on), .power_off_i(pwr_off),
    .resume_i(resume), .logic_good_i(lgood), .intf_good_i(igood), .rails_low_i(rlow),
    .power_loss_i(loss), .power_down_n_i(pdn_n), .pin_variant_i(pin), .cmd_ready_i(ready),
    .cmd_valid_o(valid), .cmd_mode_o(mode), .supply_en_o(sup), .logic_inputs_en_o(gate),
    .float_request_o(flt_o), .controller_reset_n_o(rst_n), .running_o(run_o), .parked_o(park_o)
  );

  mpps_partner #(.STBY(STBY), .FLOAT(FLT)) partner (
    .sys_clk_i(sys_clk_i), .sup_i(sup), .valid_i(valid), .mode_i(mode), .float_i(flt_o),
    .dly_i(dly), .lgood_o(lgood), .igood_o(igood), .rlow_o(rlow), .ready_o(ready), .flat_o(flat)
  );

  task automatic fail(input string msg);
    mismatches++;
    $display("MISMATCH at %0t: %s", $time, msg);
  endtask

  task automatic chk_bit(input logic e, input logic g, input string msg);
    total_checks++;
    if (g !== e)
      fail(msg);
  endtask

  task automatic chk_sup(input mpps_supply_s e, input mpps_supply_s g);
    total_checks++;
    if (g !== e)
      fail($sformatf("supplies %b expected %b", g, e));
  endtask

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watches every cycle; the queue holds the supply steps the sequence must walk through
  always @(posedge sys_clk_i) begin
    prev_s <= sup;
    prev_v <= valid;
    prev_r <= ready;
    prev_m <= mode;
    prev_rn <= rst_n;
    rst_lo  <= (rst_n === 1'b0) ? rst_lo + 1 : 0;
    cycles++;
    if (cycles == 6000) begin
      fail("timeout");
      close_out();
    end
    if (!srst_i) begin
      if (sup !== prev_s && exp_q.size() == 0)
        fail("extra supply step");
      else if (sup !== prev_s)
        chk_sup(exp_q.pop_front(), sup);
      if (sup.offset_en || sup.bias_en || sup.mreset_en)
        chk_bit(1'b1, lgood && igood, "rails before core");
      chk_bit(1'b1, (lgood && igood) || !(gate || flt_o || rst_n), "inputs high early");
      if (prev_s.bias_en && !sup.bias_en)
        chk_bit(1'b1, flat, "rails dropped before park");
      if (prev_s.logic_en && !sup.logic_en)
        chk_bit(1'b1, rlow, "core dropped early");
      if (prev_v && !prev_r)
        chk_bit(1'b1, valid && mode === prev_m, "command withdrawn");
      if (valid && ready)
        saw_stby <= (mode === CMD_STANDBY);
      if (flt_o)
        saw_flt <= 1'b1;
      if (park_o) begin
        saw_park <= 1'b1;
        chk_bit(1'b1, resume, "parked without resume");
      end
      if (valid && ready && mode === CMD_NORMAL)
        saw_norm <= 1'b1;
      if (rst_n && !prev_rn && saw_park)
        chk_bit(1'b1, rst_lo == RSTL, "restart reset pulse length");
    end
  end

  task automatic run(input logic p, input int kind, input logic r);
    int n;
    pin    <= p;
    dly    <= 3'($random(seed));
    srst_i <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
    chk_sup(SUPPLY_OFF, sup);
    chk_bit(1'b0, rst_n || flt_o || valid || gate, "outputs after reset");
    exp_q    = '{5'b11000, 5'b11100, 5'b11111, 5'b11101, 5'b11000, 5'b00000};
    saw_flt  = 1'b0;
    saw_stby = 1'b0;
    saw_park = 1'b0;
    saw_norm = 1'b0;
    pwr_on <= 1'b1;
    @(posedge sys_clk_i);
    pwr_on <= 1'b0;
    n = 0;
    while (run_o !== 1'b1 && n < 100) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk_bit(1'b1, run_o, "not running");
    repeat (2 + ($random(seed) & 7)) @(posedge sys_clk_i);
    case (kind)
      0: pwr_off <= 1'b1;
      1: loss <= 1'b1;
      default: pdn_n <= 1'b0;
    endcase
    resume <= r;
    @(posedge sys_clk_i);
    pwr_off <= 1'b0;
    if (r) begin
      n = 0;
      while (park_o !== 1'b1 && n < 200) begin
        @(posedge sys_clk_i);
        n++;
      end
      chk_bit(1'b1, park_o, "not parked");
      n = 0;
      while (run_o !== 1'b1 && n < 200) begin
        @(posedge sys_clk_i);
        n++;
      end
      chk_bit(1'b1, run_o, "no restart from park");
      chk_bit(!p, saw_norm, "normal command");
      resume  <= 1'b0;
      pwr_off <= 1'b1;
      @(posedge sys_clk_i);
      pwr_off <= 1'b0;
    end
    n = 0;
    while (sup !== SUPPLY_OFF && n < 200) begin
      @(posedge sys_clk_i);
      n++;
    end
    // One more edge so the watcher has consumed the last step
    @(posedge sys_clk_i);
    chk_sup(SUPPLY_OFF, sup);
    chk_bit(p, saw_flt, "float request");
    chk_bit(!p, saw_stby, "standby command");
    chk_bit(1'b1, exp_q.size() == 0, "missing supply step");
    loss  <= 1'b0;
    pdn_n <= 1'b1;
    $display("Test pin=%0d kind=%0d resume=%0d done", p, kind, r);
  endtask

  initial begin
    run(1'b1, 0, 1'b0);
    run(1'b0, 0, 1'b0);
    run(1'b0, 1, 1'b0);
    run(1'b1, 1, 1'b0);
    run(1'b1, 2, 1'b0);
    run(1'b0, 2, 1'b0);
    run(1'b1, 0, 1'b1);
    run(1'b0, 0, 1'b1);
    close_out();
  end
endmodule
